/* File: verilog/amw_ctrl.sv */
// module: host controller issuing strobe-ended writes to async memory
`timescale 1ns/1ns
module amw_ctrl
    import amw_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         resetn,
    input  wire logic         req_valid,
    output logic              req_ready,
    input  wire amw_req_type  req,
    output amw_pins_type      pins,
    output logic [DATA_W-1:0] dq_out,
    output logic              dq_oe_n,
    input  wire logic [DATA_W-1:0] dq_in
);
    // sequencer state and the shared down counter
    amw_state_type     state_q;
    amw_state_type     state_d;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  cnt_d;

    // captured request; the lanes are applied one cycle after capture
    amw_req_type       req_q;

    // pin registers, one per concern, joined into the pin struct and data outputs below
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] data_q;
    logic              data_oe_n_q;
    logic              select_n_q;
    logic              strobe_n_q;
    logic              drive_n_q;
    logic              upper_n_q;
    logic              lower_n_q;

    // decoded events of the sequencer
    logic              take_w;
    logic              pulse_end_w;
    logic              recover_end_w;
    logic [DATA_W-1:0] unused_dq;

    // true on the last cycle of a counted phase; both phases end this way
    function automatic logic count_done(input logic [CNT_W-1:0] cnt);
        count_done = (cnt == 4'h1);
    endfunction

    // next counter value inside a phase; only used before the count is
    // done, so it never wraps below zero
    function automatic logic [CNT_W-1:0] count_step(
        input logic [CNT_W-1:0] cnt
    );
        count_step = cnt - 4'h1;
    endfunction

    // lane enables are active high on the user side, low on the pins
    function automatic logic lane_pin(input logic lane_en);
        lane_pin = !lane_en;
    endfunction

    // data pins are never read by a write-only controller
    assign unused_dq = dq_in;

    // a new write is taken only while idle; a request made while busy
    // is ignored, so the user must hold it until ready is seen
    assign req_ready = (state_q == AMW_IDLE);
    assign take_w    = req_valid && req_ready;

    // phase ends: the pulse and the recovery both run out on count one
    assign pulse_end_w   = (state_q == AMW_PULSE) && count_done(cnt_q);
    assign recover_end_w = (state_q == AMW_RECOVER) && count_done(cnt_q);

    // next state: address first, strobe low for the pulse, then recovery
    always_comb begin
        state_d = state_q;
        case (state_q)
            AMW_IDLE: begin
                if (take_w) begin
                    state_d = AMW_SETUP;
                end
            end
            AMW_SETUP: begin
                state_d = AMW_PULSE;
            end
            AMW_PULSE: begin
                if (pulse_end_w) begin
                    state_d = AMW_RECOVER;
                end
            end
            AMW_RECOVER: begin
                // recovery also covers the 2 ns high hold and cycle time
                if (recover_end_w) begin
                    state_d = AMW_IDLE;
                end
            end
            default: begin
                state_d = AMW_IDLE;
            end
        endcase
    end

    // state register; a reset in mid-pulse lifts every control pin at
    // once, so a cut write may leave a partly stored word behind
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= AMW_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // counter next value: loaded on phase entry, counted down within
    always_comb begin
        cnt_d = cnt_q;
        case (state_q)
            AMW_SETUP: begin
                cnt_d = PULSE_CNT;
            end
            AMW_PULSE: begin
                if (pulse_end_w) begin
                    cnt_d = REC_CNT;
                end else begin
                    cnt_d = count_step(cnt_q);
                end
            end
            AMW_RECOVER: begin
                // recovery is padded only up to the least cycle length; here none is needed
                if (!recover_end_w) begin
                    cnt_d = count_step(cnt_q);
                end
            end
            default: begin
                cnt_d = cnt_q;
            end
        endcase
    end

    // counter register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // request capture; the lanes are read from here in the setup cycle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            req_q <= '0;
        end else if (take_w) begin
            req_q <= req;
        end
    end

    // address and data change only when a write is taken, so they stand
    // from setup through recovery and past the end of the write
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            addr_q <= '0;
            data_q <= '0;
        end else if (take_w) begin
            addr_q <= req.addr;
            data_q <= req.data;
        end
    end

    // data drive: on from the taking edge until the edge that enters idle;
    // the hold after the rising strobe is two full cycles, above zero
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            data_oe_n_q <= 1'b1;
        end else begin
            data_oe_n_q <= !(take_w ||
                state_q == AMW_SETUP ||
                state_q == AMW_PULSE ||
                (state_q == AMW_RECOVER && !recover_end_w));
        end
    end

    // select and strobe fall and rise on the same edge, so the write is
    // ended by both at once and the overlap is the whole pulse
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            select_n_q <= 1'b1;
            strobe_n_q <= 1'b1;
        end else if (state_q == AMW_SETUP) begin
            select_n_q <= 1'b0;
            strobe_n_q <= 1'b0;
        end else if (pulse_end_w) begin
            select_n_q <= 1'b1;
            strobe_n_q <= 1'b1;
        end
    end

    // lanes share the select edges: one flop edge, so no skew between
    // them, at the cost of never ending a write by the lanes alone
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            upper_n_q <= 1'b1;
            lower_n_q <= 1'b1;
        end else if (state_q == AMW_SETUP) begin
            upper_n_q <= lane_pin(req_q.lane_en[1]);
            lower_n_q <= lane_pin(req_q.lane_en[0]);
        end else if (pulse_end_w) begin
            upper_n_q <= 1'b1;
            lower_n_q <= 1'b1;
        end
    end

    // memory outputs stay off; this block only writes, so the memory
    // never drives the data pins against the host
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            drive_n_q <= 1'b1;
        end else begin
            drive_n_q <= 1'b1;
        end
    end

    // pin struct and data outputs, all straight from flip-flops
    assign pins = '{addr:           addr_q,
                    chip_pick_n:    select_n_q,
                    store_strobe_n: strobe_n_q,
                    output_drive_n: drive_n_q,
                    upper_lane_n:   upper_n_q,
                    lower_lane_n:   lower_n_q};
    assign dq_out  = data_q;
    assign dq_oe_n = data_oe_n_q;
endmodule

/* File: verilog/amw_pkg.sv */
// package: pin timing, types and states of the async memory write controller
package amw_pkg;
    localparam int CLK_PERIOD_NS   = 10;
    localparam int CYCLE_NS        = 35;
    localparam int ADDR_TO_END_NS  = 20;
    localparam int DATA_TO_END_NS  = 10;
    localparam int PULSE_NS        = 15;
    localparam int RECOVERY_NS     = 12;
    localparam int HIGH_HOLD_NS    = 2;
    // least times round up to whole cycles
    localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REC_CYC   =
        (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC  =
        (HIGH_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_CYC   = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC = 1;
    // total busy cycles from address valid to the return to idle
    localparam int TOTAL_RAW = SETUP_CYC + PULSE_CYC + REC_CYC;
    localparam int TOTAL_CYC = (TOTAL_RAW > CYC_CYC) ? TOTAL_RAW : CYC_CYC;
    localparam int CNT_W     = 4;
    localparam logic [CNT_W-1:0] PULSE_CNT = CNT_W'(PULSE_CYC);
    localparam logic [CNT_W-1:0] REC_CNT   =
        CNT_W'(TOTAL_CYC - SETUP_CYC - PULSE_CYC);
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;

    // write request from the user side
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [1:0]        lane_en;  // [1] upper, [0] lower, active high
    } amw_req_type;

    // pins toward the memory (control pins active low)
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              chip_pick_n;
        logic              store_strobe_n;
        logic              output_drive_n;
        logic              upper_lane_n;
        logic              lower_lane_n;
    } amw_pins_type;

    // gray coded along idle -> setup -> pulse -> recover
    typedef enum logic [1:0] {
        AMW_IDLE    = 2'b00,
        AMW_SETUP   = 2'b01,
        AMW_PULSE   = 2'b11,
        AMW_RECOVER = 2'b10
    } amw_state_type;
endpackage

/* File: tb/amw_ctrl_asserts.sv */
// checker: pin timing assertions of the write controller
`timescale 1ns/1ns
module amw_ctrl_asserts
    import amw_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              resetn,
    input wire logic              req_valid,
    input wire logic              req_ready,
    input wire amw_req_type       req,
    input wire amw_pins_type      pins,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic              dq_oe_n,
    input wire logic [DATA_W-1:0] dq_in
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_strobe_pair: assert property (pins.chip_pick_n ==
        pins.store_strobe_n) else $error("select and strobe apart");
    a_pulse_two: assert property ($fell(pins.store_strobe_n) |=>
        !pins.store_strobe_n ##1 pins.store_strobe_n) else $error("pulse");
    a_high_hold: assert property ($rose(pins.store_strobe_n) |->
        pins.store_strobe_n[*2]) else $error("strobe high too short");
    a_cycle_space: assert property ($fell(pins.chip_pick_n) |=>
        (!$fell(pins.chip_pick_n))[*3]) else $error("cycle too short");
    a_data_drive: assert property (!pins.store_strobe_n |->
        !dq_oe_n && $stable(dq_out)) else $error("data not held");
    a_addr_hold: assert property (!pins.store_strobe_n |->
        $stable(pins.addr)) else $error("address moved");
    a_drive_off: assert property (pins.output_drive_n)
        else $error("output drive low");
    a_lane_idle: assert property (pins.store_strobe_n |->
        pins.upper_lane_n && pins.lower_lane_n) else $error("lane low");
    a_lane_map: assert property ($fell(pins.store_strobe_n) |->
        {pins.upper_lane_n, pins.lower_lane_n} == ~$past(req.lane_en, 2)
        && dq_out == $past(req.data, 2)) else $error("lane or data wrong");
    a_ready_back: assert property ($fell(req_ready) |->
        (!req_ready)[*5] ##1 req_ready) else $error("busy time wrong");
endmodule
bind amw_ctrl amw_ctrl_asserts u_chk (.core_clk, .resetn, .req_valid,
    .req_ready, .req, .pins, .dq_out, .dq_oe_n, .dq_in);

/* File: tb/amw_mem_model.sv */
// partner: word memory answering the controller's write pins
`timescale 1ns/1ns
module amw_mem_model
    import amw_pkg::*;
(
    input wire amw_pins_type      pins,
    input wire logic [DATA_W-1:0] dq
);
    logic [DATA_W-1:0] cells [16];
    initial foreach (cells[i]) cells[i] = 16'h0000;
    // store during the overlap only; output drive is never honoured and
    // the data pins are never driven here, so the host cannot collide
    always @* begin
        if (!pins.chip_pick_n && !pins.store_strobe_n) begin
            if (!pins.upper_lane_n) begin
                cells[pins.addr[3:0]][15:8] = dq[15:8];
            end
            if (!pins.lower_lane_n) begin
                cells[pins.addr[3:0]][7:0] = dq[7:0];
            end
        end
    end
endmodule

/* File: tb/amw_ctrl_test.sv */
// testbench: writes through the controller into the memory model
`timescale 1ns/1ns
module amw_ctrl_test import amw_pkg::*;;
    logic core_clk = 0, resetn = 0, req_valid = 0, dq_oe_n, req_ready;
    amw_req_type req = '0;
    amw_pins_type pins;
    logic [DATA_W-1:0] dq_out, bus, last = '0;
    int err_count = 0, n_tests = 0;
    initial forever #5 core_clk = ~core_clk;
    // a released bus shows the inverse of the last word, not a stale copy
    always @(posedge core_clk) if (!dq_oe_n) last <= dq_out;
    assign bus = dq_oe_n ? ~last : dq_out;
    amw_ctrl DUT (.core_clk, .resetn, .req_valid, .req_ready, .req,
        .pins, .dq_out, .dq_oe_n, .dq_in(bus));
    amw_mem_model u_mem (.pins, .dq(bus));
    task tally_and_finish;
        $display("errors %0d tests %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wait_ready;
        int n;
        n = 0;
        while (req_ready !== 1'b1) begin
            if (++n > 20) begin
                err_count++;
                $display("MISMATCH %0t ready timeout", $time);
                tally_and_finish;
            end
            @(posedge core_clk); #1;
        end
    endtask
    task wr(input logic [19:0] a, input logic [15:0] d, input logic [1:0] l);
        wait_ready;
        req = '{a, d, l};
        req_valid = 1;
        @(posedge core_clk); #1;
        req_valid = 0;
    endtask
    task s_lanes;
        for (int l = 0; l < 4; l++) wr(20'(4 + l), 16'h1234, 2'(l));
        wait_ready;
        for (int l = 0; l < 4; l++) cmp(u_mem.cells[4 + l],
            {l[1] ? 8'h12 : 8'h00, l[0] ? 8'h34 : 8'h00});
    endtask
    task s_back;
        wr(20'h00002, 16'hBEEF, 2'h3);
        wr(20'h00003, 16'hCAFE, 2'h3);
        wr(20'h00002, 16'h0011, 2'h1);
        wait_ready;
        cmp(u_mem.cells[2], 16'hBE11);
        cmp(u_mem.cells[3], 16'hCAFE);
    endtask
    task s_reset;
        wr(20'h00009, 16'hAAAA, 2'h3);
        @(posedge core_clk); #1;
        cmp(16'(pins[4:0]), 16'h0004);
        resetn = 0;
        #1 cmp(16'({pins[4:0], dq_oe_n, req_ready}), 16'h007F);
        cmp(pins.addr[15:0], 16'h0000);
        @(posedge core_clk); #1 resetn = 1;
        wr(20'h00009, 16'h5AC3, 2'h3);
        wait_ready;
        cmp(u_mem.cells[9], 16'h5AC3);
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        #1 resetn = 1;
        s_lanes;
        s_back;
        s_reset;
        s_back;
        tally_and_finish;
    end
endmodule
